/* File: ptpi_core_model.sv */
// core-side partner model: takes interrupt entry on command, pops on return
// assumes the bench pulses take_i and ret_i for one cycle just after an edge

`timescale 1ns/1ns

module ptpi_core_model (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      irq_high_i,
  input  wire logic                      irq_low_i,
  input  wire logic                      take_i,
  input  wire logic                      ret_i,
  input  wire logic [ptpi_pkg::PC_W-1:0] pc_i,
  output logic                           core_entry_o,
  output ptpi_pkg::ptpi_ctx_t            core_ctx_o,
  output logic                           core_return_o
);
  import ptpi_pkg::*;

  // ----------------------------------------
  // entry and return
  // ----------------------------------------
  // entry only while a request stands; context flips between entries so a
  // store at the wrong edge shows up as a wrong value, not a lucky match
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      core_entry_o  <= 1'b0;
      core_return_o <= 1'b0;
      core_ctx_o    <= '0;
    end else begin
      core_entry_o  <= take_i & (irq_high_i | irq_low_i);
      // plain return: nothing comes back from the shadow, the service code
      // keeps its own copies of working, status and bank select
      core_return_o <= ret_i;
      if (take_i) begin
        core_ctx_o <= {pc_i, pc_i[7:0], pc_i[15:8], 3'b000, pc_i[20:16]};
      end else begin
        core_ctx_o <= ~core_ctx_o;
      end
    end
  end
endmodule // ptpi_core_model

/* File: ptpi_irq_src.sv */
// interrupt source logic: four edge pins, timer overflow, port change,
// wake control and the context saved on interrupt entry
// assumes apb3 master on the same clock, pins asynchronous to the clock
//
// Function
// RULE1: each pin interrupt is edge triggered, rising when its polarity bit is set, else falling.
// RULE2: a qualifying edge on a pin sets that pin's flag. The code sets no pin flag while the power state is deep sleep.
// RULE3: a cleared pin enable keeps that pin's flag from requesting the core.
// RULE4: software clears a pin flag before enabling the interrupt again; hardware never clears it.
// RULE5: any pin wakes the core from sleep or idle if its enable was set before entry.
// RULE6: only pin zero wakes from deep sleep, and that wake restarts at the reset vector.
// RULE7: pins one and two take priority from bits 6 and 7 of the third control, pin three from bit 1 of the second.
// RULE8: pin zero has no priority bit and is always high priority.
// RULE9: in 8-bit timer mode a roll from all ones to zero sets the overflow flag.
// RULE10: in 16-bit timer mode a roll of the count pair from all ones to zero sets the same flag.
// RULE11: the overflow request is gated by bit 5 of the first control, priority bit 2 of the second.
// RULE12: any level change on the upper port nibble sets the port change flag, bit 0 of the first control.
// RULE13: the port change request is gated by bit 3 of the first control, priority bit 0 of the second.
// RULE14: interrupt entry pushes the return address onto the hardware return stack.
// RULE15: interrupt entry copies working, status and bank select registers into the shadow.
// RULE16: without a fast return, software saves the working, status and bank select registers itself.
// RULE17: a source with flag and enable set requests the high or low vector by its priority bit.

`timescale 1ns/1ns

module ptpi_irq_src (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  // apb slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // pins
  input  wire logic [ptpi_pkg::PINS-1:0]  ext_irq_pin_i,
  input  wire logic [3:0]                 upper_nibble_port_i,
  // core side
  input  wire logic                       core_entry_i,
  input  wire ptpi_pkg::ptpi_ctx_t        core_ctx_i,
  input  wire logic                       core_return_i,
  output logic                            irq_high_o,
  output logic                            irq_low_o,
  output logic                            wake_o,
  output logic                            deep_wake_reset_o,
  output logic      [ptpi_pkg::PC_W-1:0]  ret_stack_top_o,
  output ptpi_pkg::ptpi_shadow_t          shadow_o,
  output logic                            irq_o
);
  import ptpi_pkg::*;

  ptpi_state_t r;
  ptpi_state_t n;

  logic [PINS-1:0] pin_chg;
  logic [PINS-1:0] pin_edge;
  logic [PINS-1:0] pin_flag;
  logic [PINS-1:0] pin_en;
  logic [PINS-1:0] pin_prio;
  logic [PINS-1:0] edge_polarity_sel;
  logic            port_chg;
  logic            tmr_ovf;
  logic            deep;
  logic [5:0]      src_flag;
  logic [5:0]      src_en;
  logic [5:0]      src_prio;
  logic [5:0]      src_req;
  logic            acc;
  logic            wr;
  logic            hit;
  logic [31:0]     rd_mux;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // word address compare, used by read and write decode
  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    return (a[7:2] == off[7:2]);
  endfunction

  // ----------------------------------------
  // source view of the control registers
  // ----------------------------------------
  // pin zero has no priority bit and is tied high
  assign edge_polarity_sel = r.ctl_second[CS_POL_LSB +: PINS];
  assign pin_flag = {r.ctl_third[CT_FLAG_LSB +: 3], r.ctl_first[CF_PIN0_FLAG]};
  assign pin_en   = {r.ctl_third[CT_EN_LSB +: 3], r.ctl_first[CF_PIN0_EN]};
  assign pin_prio = {r.ctl_second[CS_PIN3_PRIO], r.ctl_third[CT_PIN2_PRIO],
                     r.ctl_third[CT_PIN1_PRIO], 1'b1}; // RULE7 RULE8
  assign src_flag = {r.ctl_first[CF_PORT_FLAG], r.ctl_first[CF_TMR_FLAG], pin_flag};
  assign src_en   = {r.ctl_first[CF_PORT_EN], r.ctl_first[CF_TMR_EN], pin_en}; // RULE11 RULE13
  assign src_prio = {r.ctl_second[CS_PORT_PRIO], r.ctl_second[CS_TMR_PRIO], pin_prio};
  assign src_req  = src_flag & src_en; // RULE3

  // requests routed by priority
  assign irq_high_o = |(src_req & src_prio); // RULE17
  assign irq_low_o  = |(src_req & ~src_prio); // RULE17

  // ----------------------------------------
  // pin and port edge detection
  // ----------------------------------------
  // a level counts only once the second and third stage agree
  assign pin_chg  = ~(r.pin_s2 ^ r.pin_s3) & (r.pin_s3 ^ r.pin_q);
  assign pin_edge = pin_chg & ~(r.pin_s3 ^ edge_polarity_sel); // RULE1
  assign port_chg = |(~(r.prt_s2 ^ r.prt_s3) & (r.prt_s3 ^ r.prt_q)); // RULE12
  assign deep     = (r.pwr == PWR_DEEP);

  // timer roll from all ones, width chosen by mode
  assign tmr_ovf = r.tmr_ctl[TC_RUN] &
                   (r.tmr_ctl[TC_WIDE] ? (r.tmr_cnt == 16'hFFFF) // RULE10
                                       : (r.tmr_cnt[7:0] == 8'hFF)); // RULE9

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign acc = psel_i & penable_i;
  assign wr  = acc & pwrite_i;
  assign hit = at(paddr_i, OFF_CTL_FIRST) | at(paddr_i, OFF_CTL_SECOND) |
               at(paddr_i, OFF_CTL_THIRD) | at(paddr_i, OFF_TMR_CTL) |
               at(paddr_i, OFF_TMR_CNT) | at(paddr_i, OFF_EV_STAT) |
               at(paddr_i, OFF_EV_MASK) | at(paddr_i, OFF_PWR) |
               at(paddr_i, OFF_STK);

  // read data is captured in the setup cycle, so the answer has no wait state
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~hit;
  assign prdata_o  = r.prdata;

  // read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (at(paddr_i, OFF_CTL_FIRST)) begin
      rd_mux[7:0] = r.ctl_first;
    end else if (at(paddr_i, OFF_CTL_SECOND)) begin
      rd_mux[7:0] = r.ctl_second;
    end else if (at(paddr_i, OFF_CTL_THIRD)) begin
      rd_mux[7:0] = r.ctl_third;
    end else if (at(paddr_i, OFF_TMR_CTL)) begin
      rd_mux[1:0] = r.tmr_ctl;
    end else if (at(paddr_i, OFF_TMR_CNT)) begin
      rd_mux[15:0] = r.tmr_cnt;
    end else if (at(paddr_i, OFF_EV_STAT)) begin
      rd_mux[EV_W-1:0] = r.ev_stat;
    end else if (at(paddr_i, OFF_EV_MASK)) begin
      rd_mux[EV_W-1:0] = r.ev_mask;
    end else if (at(paddr_i, OFF_PWR)) begin
      rd_mux[1:0] = r.pwr;
    end else if (at(paddr_i, OFF_STK)) begin
      rd_mux[PC_W-1:0] = r.stk[0];
      rd_mux[27:24]    = r.stk_cnt;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = r;
    // three stage synchronisers; only the stable copy is used
    n.pin_s1 = ext_irq_pin_i;
    n.pin_s2 = r.pin_s1;
    n.pin_s3 = r.pin_s2;
    n.pin_q  = r.pin_q ^ pin_chg;
    n.prt_s1 = upper_nibble_port_i;
    n.prt_s2 = r.prt_s1;
    n.prt_s3 = r.prt_s2;
    n.prt_q  = (~(r.prt_s2 ^ r.prt_s3) & r.prt_s3) | ((r.prt_s2 ^ r.prt_s3) & r.prt_q);
    n.wake      = 1'b0;
    n.deep_wake = 1'b0;

    // read data captured at setup, held through the access phase
    if (psel_i & ~penable_i & ~pwrite_i) begin
      n.prdata = rd_mux;
    end

    // software writes first, hardware sets below so a set always wins
    if (wr & at(paddr_i, OFF_CTL_FIRST)) begin
      n.ctl_first = pwdata_i[7:0]; // RULE4
    end
    if (wr & at(paddr_i, OFF_CTL_SECOND)) begin
      n.ctl_second = pwdata_i[7:0];
    end
    if (wr & at(paddr_i, OFF_CTL_THIRD)) begin
      n.ctl_third = pwdata_i[7:0]; // RULE4
    end
    if (wr & at(paddr_i, OFF_TMR_CTL)) begin
      n.tmr_ctl = pwdata_i[1:0];
    end
    if (wr & at(paddr_i, OFF_EV_MASK)) begin
      n.ev_mask = pwdata_i[EV_W-1:0];
    end

    // timer: 8-bit mode counts the low byte only
    if (wr & at(paddr_i, OFF_TMR_CNT)) begin
      n.tmr_cnt = pwdata_i[15:0];
    end else if (r.tmr_ctl[TC_RUN]) begin
      if (r.tmr_ctl[TC_WIDE]) begin
        n.tmr_cnt = r.tmr_cnt + 16'h0001; // RULE10
      end else begin
        n.tmr_cnt[7:0] = r.tmr_cnt[7:0] + 8'h01; // RULE9
      end
    end

    // flags: pin edges are ignored in deep sleep, where only a reset follows
    if (!deep) begin
      n.ctl_first[CF_PIN0_FLAG] = n.ctl_first[CF_PIN0_FLAG] | pin_edge[0]; // RULE2
      n.ctl_third[CT_FLAG_LSB +: 3] = n.ctl_third[CT_FLAG_LSB +: 3] | pin_edge[3:1]; // RULE2
    end
    n.ctl_first[CF_TMR_FLAG]  = n.ctl_first[CF_TMR_FLAG] | tmr_ovf; // RULE9 RULE10
    n.ctl_first[CF_PORT_FLAG] = n.ctl_first[CF_PORT_FLAG] | port_chg; // RULE12

    // sticky event status; a read clears only what it reported
    n.ev_stat = r.ev_stat;
    if (acc & ~pwrite_i & at(paddr_i, OFF_EV_STAT)) begin
      n.ev_stat = r.ev_stat & ~r.prdata[EV_W-1:0];
    end
    n.ev_stat = n.ev_stat | {port_chg, tmr_ovf, pin_edge & {PINS{~deep}}};

    // power state; enables are snapshot on entry so later changes do not wake
    if (wr & at(paddr_i, OFF_PWR)) begin
      n.pwr     = ptpi_pwr_t'(pwdata_i[1:0]);
      n.wake_en = pin_en; // RULE5
    end else begin
      case (r.pwr)
        PWR_IDLE, PWR_SLEEP: begin
          if (|(pin_edge & r.wake_en)) begin
            n.pwr  = PWR_RUN; // RULE5
            n.wake = 1'b1;
          end
        end
        PWR_DEEP: begin
          if (pin_edge[0]) begin
            n.pwr       = PWR_RUN; // RULE6
            n.deep_wake = 1'b1;
          end
        end
        PWR_RUN: begin
          n.pwr = PWR_RUN;
        end
        default: begin
          n.pwr = PWR_RUN;
        end
      endcase
    end

    // return stack and shadow; a push on a full stack drops the oldest entry
    if (core_entry_i) begin
      n.stk    = {r.stk[STK_DEPTH-2:0], core_ctx_i.pc}; // RULE14
      n.shadow = '{working_register: core_ctx_i.working_register, status: core_ctx_i.status,
                   bank_select_register: core_ctx_i.bank_select_register}; // RULE15
      if (r.stk_cnt != 4'(STK_DEPTH)) begin
        n.stk_cnt = r.stk_cnt + 4'h1;
      end
    end else if (core_return_i) begin
      n.stk = {{PC_W{1'b0}}, r.stk[STK_DEPTH-1:1]};
      if (r.stk_cnt != 4'h0) begin
        n.stk_cnt = r.stk_cnt - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r            <= '0;
      r.ctl_second <= CTL_SECOND_RST;
      r.pwr        <= PWR_RUN;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign wake_o            = r.wake;
  assign deep_wake_reset_o = r.deep_wake;
  assign ret_stack_top_o   = r.stk[0];
  assign shadow_o          = r.shadow;
  assign irq_o             = |(r.ev_stat & r.ev_mask);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_POLARITY: assert property ( // RULE1
    pin_edge[1] |=> (r.pin_q[1] == $past(edge_polarity_sel[1])))
    else $error("pin edge does not match polarity");

  AST_PIN_FLAG: assert property ( // RULE2
    (pin_edge[2] && !deep) |=> r.ctl_third[CT_FLAG_LSB + 1])
    else $error("pin two edge did not set its flag");

  AST_GATE: assert property ( // RULE3
    (irq_high_o || irq_low_o) |-> (|({r.ctl_first[CF_PORT_FLAG] & r.ctl_first[CF_PORT_EN],
      r.ctl_first[CF_TMR_FLAG] & r.ctl_first[CF_TMR_EN],
      r.ctl_first[CF_PIN0_FLAG] & r.ctl_first[CF_PIN0_EN],
      r.ctl_third[CT_FLAG_LSB +: 3] & r.ctl_third[CT_EN_LSB +: 3]})))
    else $error("request without enabled flag");

  AST_WAKE: assert property ( // RULE5
    ((r.pwr == PWR_SLEEP) && |(pin_edge & r.wake_en) && !wr)
      |=> (wake_o && r.pwr == PWR_RUN) ##1 !wake_o)
    else $error("sleep wake missing");

  AST_DEEP: assert property ( // RULE6
    (deep && pin_edge[0] && !wr) |=> deep_wake_reset_o && !wake_o
      && !r.ctl_first[CF_PIN0_FLAG] || $past(r.ctl_first[CF_PIN0_FLAG]))
    else $error("deep wake wrong");

  AST_PIN0_HIGH: assert property ( // RULE8
    (r.ctl_first[CF_PIN0_FLAG] && r.ctl_first[CF_PIN0_EN]) |-> irq_high_o)
    else $error("pin zero not high priority");

  AST_OVF8: assert property ( // RULE9
    (r.tmr_ctl == 2'b01 && r.tmr_cnt[7:0] == 8'hFF && !wr)
      |=> (r.tmr_cnt[7:0] == 8'h00) && r.ctl_first[CF_TMR_FLAG])
    else $error("8-bit overflow missed");

  AST_OVF16: assert property ( // RULE10
    (r.tmr_ctl == 2'b11 && r.tmr_cnt == 16'hFFFF && !wr)
      |=> (r.tmr_cnt == 16'h0000) && r.ctl_first[CF_TMR_FLAG])
    else $error("16-bit overflow missed");

  AST_PORT: assert property ( // RULE12
    $changed(r.prt_q) |-> $past(port_chg) ##0 r.ctl_first[CF_PORT_FLAG])
    else $error("port change flag missed");

  AST_STACK: assert property ( // RULE14
    core_entry_i |=> (ret_stack_top_o == $past(core_ctx_i.pc)))
    else $error("return address not pushed");

  AST_SHADOW: assert property ( // RULE15
    core_entry_i |=> (shadow_o.working_register == $past(core_ctx_i.working_register))
      && (shadow_o.bank_select_register == $past(core_ctx_i.bank_select_register)))
    else $error("shadow not loaded");

  AST_ROUTE: assert property ( // RULE17
    (r.ctl_first[CF_TMR_FLAG] && r.ctl_first[CF_TMR_EN] && !r.ctl_second[CS_TMR_PRIO])
      |-> irq_low_o)
    else $error("timer request not on low vector");

endmodule // ptpi_irq_src

/* File: ptpi_irq_src_test.sv */
// testbench for the interrupt source block: apb tasks, pins, core model
// assumes pready is sampled each access edge and pins settle in 8 cycles

`timescale 1ns/1ns

module ptpi_irq_src_test;
  import ptpi_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic             ref_clk_i = 1'b0;
  logic             rst_i     = 1'b1;
  logic             psel      = 1'b0;
  logic             penable   = 1'b0;
  logic             pwrite    = 1'b0;
  logic [7:0]       paddr     = '0;
  logic [31:0]      pwdata    = '0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [3:0]       pins      = '0;
  logic [3:0]       port      = '0;
  logic             take      = 1'b0;
  logic             ret       = 1'b0;
  logic [PC_W-1:0]  pc        = '0;
  logic             entry;
  logic             cret;
  ptpi_ctx_t        ctx;
  logic             irqh;
  logic             irql;
  logic             wake;
  logic             dwake;
  logic [PC_W-1:0]  top;
  ptpi_shadow_t     shadow;
  logic             irq;
  logic             err_seen;
  logic [31:0]      q;
  int               errors      = 0;
  int               checks_done = 0;

  // 20 MHz clock
  always #25 ref_clk_i = ~ref_clk_i;

  ptpi_irq_src uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ext_irq_pin_i(pins), .upper_nibble_port_i(port), .core_entry_i(entry),
    .core_ctx_i(ctx), .core_return_i(cret), .irq_high_o(irqh), .irq_low_o(irql),
    .wake_o(wake), .deep_wake_reset_o(dwake), .ret_stack_top_o(top),
    .shadow_o(shadow), .irq_o(irq));

  ptpi_core_model core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .irq_high_i(irqh),
    .irq_low_i(irql), .take_i(take), .ret_i(ret), .pc_i(pc), .core_entry_o(entry),
    .core_ctx_o(ctx), .core_return_o(cret));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic give_up(input string nm);
    errors++;
    $display("mismatch %s exp answer got none", nm);
    print_verdict();
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, ex, got);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) give_up("pready");
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a write has landed before any output is compared
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, ex, q);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // bounded wait for wake (sel 0) or deep wake reset (sel 1)
  task automatic wait_pulse(input int sel, input string nm);
    int n;
    n = 0;
    while (((sel == 0) ? wake : dwake) !== 1'b1 && n < 30) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 30) give_up(nm);
  endtask

  task automatic enter(input logic [PC_W-1:0] p);
    @(posedge ref_clk_i);
    take <= 1'b1;
    pc <= p;
    @(posedge ref_clk_i);
    take <= 1'b0;
    wt(3);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    wt(12);
    rst_i <= 1'b0;
    rc("ctl_second rst", OFF_CTL_SECOND, 32'h0000_007F);
    rc("ctl_first rst", OFF_CTL_FIRST, 32'h0000_0000);
    wr(8'h3C, 32'hFFFF_FFFF);
    chk("pslverr wr", 32'h0000_0001, {31'b0, err_seen});
    rc("unmapped", 8'h3C, 32'h0000_0000);
    chk("pslverr rd", 32'h0000_0001, {31'b0, err_seen});
    // pin zero rising, always high priority, then context on entry
    wr(OFF_CTL_FIRST, 32'h0000_0010);
    pins[0] <= 1'b1;
    wt(8);
    rc("pin0 flag", OFF_CTL_FIRST, 32'h0000_0012);
    chk("pin0 high", 32'h0000_0002, {30'b0, irqh, irql});
    enter(21'h1_2345);
    enter(21'h0_0ABC);
    chk("stack top", 32'h0000_0ABC, {11'b0, top});
    chk("shadow", {8'h00, 8'hBC, 8'h0A, 8'h00}, {8'h00, shadow});
    rc("stack depth", OFF_STK, 32'h0200_0ABC);
    @(posedge ref_clk_i);
    ret <= 1'b1;
    @(posedge ref_clk_i);
    ret <= 1'b0;
    wt(3);
    chk("stack pop", 32'h0001_2345, {11'b0, top});
    wr(OFF_CTL_FIRST, 32'h0000_0000);
    pins[0] <= 1'b0;
    wt(8);
    rc("pin0 fall", OFF_CTL_FIRST, 32'h0000_0000);
    // pin one falling edge, priority from the third control
    wr(OFF_CTL_SECOND, 32'h0000_006F);
    wr(OFF_CTL_THIRD, 32'h0000_0008);
    pins[1] <= 1'b1;
    wt(8);
    rc("pin1 rise", OFF_CTL_THIRD, 32'h0000_0008);
    pins[1] <= 1'b0;
    wt(8);
    rc("pin1 fall", OFF_CTL_THIRD, 32'h0000_0009);
    chk("pin1 low", 32'h0000_0001, {30'b0, irqh, irql});
    wr(OFF_CTL_THIRD, 32'h0000_0049);
    chk("pin1 hi", 32'h0000_0002, {30'b0, irqh, irql});
    wr(OFF_CTL_THIRD, 32'h0000_0041);
    chk("pin1 off", 32'h0000_0000, {30'b0, irqh, irql});
    // pin three, priority from the second control
    wr(OFF_CTL_SECOND, 32'h0000_007F);
    wr(OFF_CTL_THIRD, 32'h0000_0020);
    pins[3] <= 1'b1;
    wt(8);
    chk("pin3 hi", 32'h0000_0002, {30'b0, irqh, irql});
    wr(OFF_CTL_SECOND, 32'h0000_007D);
    chk("pin3 low", 32'h0000_0001, {30'b0, irqh, irql});
    wr(OFF_CTL_THIRD, 32'h0000_0000);
    wr(OFF_CTL_SECOND, 32'h0000_007F);
    // timer 8-bit roll keeps the high byte
    wr(OFF_CTL_FIRST, 32'h0000_0020);
    wr(OFF_TMR_CNT, 32'h0000_12FD);
    wr(OFF_TMR_CTL, 32'h0000_0001);
    wt(6);
    wr(OFF_TMR_CTL, 32'h0000_0000);
    rc("tmr8 flag", OFF_CTL_FIRST, 32'h0000_0024);
    apb(1'b0, OFF_TMR_CNT, 32'h0000_0000);
    chk("tmr8 high", 32'h0000_1200, q & 32'h0000_FF00);
    chk("tmr hi", 32'h0000_0002, {30'b0, irqh, irql});
    wr(OFF_CTL_SECOND, 32'h0000_007B);
    chk("tmr low", 32'h0000_0001, {30'b0, irqh, irql});
    wr(OFF_CTL_SECOND, 32'h0000_007F);
    // timer 16-bit: low byte roll alone sets nothing
    wr(OFF_CTL_FIRST, 32'h0000_0020);
    wr(OFF_TMR_CNT, 32'h0000_00FD);
    wr(OFF_TMR_CTL, 32'h0000_0003);
    wt(6);
    wr(OFF_TMR_CTL, 32'h0000_0000);
    rc("tmr16 none", OFF_CTL_FIRST, 32'h0000_0020);
    wr(OFF_TMR_CNT, 32'h0000_FFFD);
    wr(OFF_TMR_CTL, 32'h0000_0003);
    wt(6);
    wr(OFF_TMR_CTL, 32'h0000_0000);
    rc("tmr16 flag", OFF_CTL_FIRST, 32'h0000_0024);
    // port change on the upper nibble
    wr(OFF_CTL_FIRST, 32'h0000_0008);
    port <= 4'h5;
    wt(8);
    rc("port flag", OFF_CTL_FIRST, 32'h0000_0009);
    chk("port hi", 32'h0000_0002, {30'b0, irqh, irql});
    wr(OFF_CTL_SECOND, 32'h0000_007E);
    chk("port low", 32'h0000_0001, {30'b0, irqh, irql});
    wr(OFF_CTL_FIRST, 32'h0000_0000);
    wr(OFF_CTL_SECOND, 32'h0000_007F);
    // sticky status, mask, level interrupt, clear on read
    chk("irq masked", 32'h0000_0000, {31'b0, irq});
    wr(OFF_EV_MASK, 32'h0000_003F);
    rc("mask", OFF_EV_MASK, 32'h0000_003F);
    chk("irq on", 32'h0000_0001, {31'b0, irq});
    rc("status", OFF_EV_STAT, 32'h0000_003B);
    wt(1);
    chk("irq off", 32'h0000_0000, {31'b0, irq});
    rc("status clr", OFF_EV_STAT, 32'h0000_0000);
    // wake from idle by an enabled pin, none from sleep when disabled
    wr(OFF_CTL_THIRD, 32'h0000_0010);
    wr(OFF_PWR, 32'h0000_0001);
    pins[2] <= 1'b1;
    wait_pulse(0, "wake_o");
    wt(2);
    rc("idle woke", OFF_PWR, 32'h0000_0000);
    wr(OFF_CTL_THIRD, 32'h0000_0000);
    wr(OFF_PWR, 32'h0000_0003);
    pins[1] <= 1'b1;
    wt(10);
    rc("sleep kept", OFF_PWR, 32'h0000_0003);
    // sleep left by an enabled pin one on its falling edge
    wr(OFF_CTL_SECOND, 32'h0000_006F);
    wr(OFF_CTL_THIRD, 32'h0000_0008);
    wr(OFF_PWR, 32'h0000_0003);
    pins[1] <= 1'b0;
    wait_pulse(0, "sleep wake");
    wt(2);
    rc("sleep woke", OFF_PWR, 32'h0000_0000);
    // deep sleep left only by pin zero, through the reset vector
    wr(OFF_CTL_FIRST, 32'h0000_0000);
    wr(OFF_PWR, 32'h0000_0002);
    pins[0] <= 1'b1;
    wait_pulse(1, "deep wake");
    wt(2);
    rc("deep woke", OFF_PWR, 32'h0000_0000);
    rc("deep no flag", OFF_CTL_FIRST, 32'h0000_0000);
    print_verdict();
  end
endmodule // ptpi_irq_src_test

/* File: ptpi_pkg.sv */
// package for the pin, timer and port-change interrupt source logic
// assumes one 20 MHz clock, a synchronous reset and an apb3 register port

package ptpi_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned PINS      = 4;
  localparam int unsigned PC_W      = 21;
  localparam int unsigned STK_DEPTH = 8;
  localparam int unsigned EV_W      = 6;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTL_FIRST  = 8'h00;
  localparam logic [7:0] OFF_CTL_SECOND = 8'h04;
  localparam logic [7:0] OFF_CTL_THIRD  = 8'h08;
  localparam logic [7:0] OFF_TMR_CTL    = 8'h0C;
  localparam logic [7:0] OFF_TMR_CNT    = 8'h10;
  localparam logic [7:0] OFF_EV_STAT    = 8'h14;
  localparam logic [7:0] OFF_EV_MASK    = 8'h18;
  localparam logic [7:0] OFF_PWR        = 8'h1C;
  localparam logic [7:0] OFF_STK        = 8'h20;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned CF_PORT_FLAG = 0;
  localparam int unsigned CF_PIN0_FLAG = 1;
  localparam int unsigned CF_TMR_FLAG  = 2;
  localparam int unsigned CF_PORT_EN   = 3;
  localparam int unsigned CF_PIN0_EN   = 4;
  localparam int unsigned CF_TMR_EN    = 5;
  localparam int unsigned CS_PORT_PRIO = 0;
  localparam int unsigned CS_PIN3_PRIO = 1;
  localparam int unsigned CS_TMR_PRIO  = 2;
  localparam int unsigned CS_POL_LSB   = 3;
  localparam int unsigned CT_FLAG_LSB  = 0;
  localparam int unsigned CT_EN_LSB    = 3;
  localparam int unsigned CT_PIN1_PRIO = 6;
  localparam int unsigned CT_PIN2_PRIO = 7;
  localparam int unsigned TC_RUN       = 0;
  localparam int unsigned TC_WIDE      = 1;
  localparam int unsigned EV_TMR       = 4;
  localparam int unsigned EV_PORT      = 5;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CTL_SECOND_RST = 8'h7F;

  // power states, gray coded along run-idle-sleep-deep
  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_IDLE  = 2'b01,
    PWR_SLEEP = 2'b11,
    PWR_DEEP  = 2'b10
  } ptpi_pwr_t;

  // context offered by the core on interrupt entry
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [7:0]      working_register;
    logic [7:0]      status;
    logic [7:0]      bank_select_register;
  } ptpi_ctx_t;

  // fast return shadow
  typedef struct packed {
    logic [7:0] working_register;
    logic [7:0] status;
    logic [7:0] bank_select_register;
  } ptpi_shadow_t;

  // whole block state
  typedef struct packed {
    logic [PINS-1:0]                 pin_s1;
    logic [PINS-1:0]                 pin_s2;
    logic [PINS-1:0]                 pin_s3;
    logic [PINS-1:0]                 pin_q;
    logic [3:0]                      prt_s1;
    logic [3:0]                      prt_s2;
    logic [3:0]                      prt_s3;
    logic [3:0]                      prt_q;
    logic [7:0]                      ctl_first;
    logic [7:0]                      ctl_second;
    logic [7:0]                      ctl_third;
    logic [1:0]                      tmr_ctl;
    logic [15:0]                     tmr_cnt;
    logic [EV_W-1:0]                 ev_stat;
    logic [EV_W-1:0]                 ev_mask;
    ptpi_pwr_t                       pwr;
    logic [PINS-1:0]                 wake_en;
    logic                            wake;
    logic                            deep_wake;
    logic [STK_DEPTH-1:0][PC_W-1:0]  stk;
    logic [3:0]                      stk_cnt;
    ptpi_shadow_t                    shadow;
    logic [31:0]                     prdata;
  } ptpi_state_t;

endpackage
